//--- include/atr_consts.svh
// constants for the read-multiple / native-max task-file link
// What this block does
// - opcode C4h reads sectors, 28-bit addressing
// - sector data moves as 16-bit words
// - one interrupt per block, not per sector
// - opcode 29h reads with 48-bit addressing
// - host gives count: current low, previous high
// - 48-bit count zero means 65,536 sectors
// - host gives 48-bit LBA in current/previous bytes
// - error returns failing LBA, split by HOB
// - opcode F8h returns unreduced native maximum address
// - above 28-bit range report 268,435,455
// - LBA bits 0-7 in sector number
// - LBA 8-15 cylinder low, 16-23 high
// - CHS mode reports max sector and cylinder
// - 28-bit count zero means 256 sectors
// - media error stops read at failing sector
// - sector count returns sectors not transferred
// - device/head low nibble carries LBA 24-27
`ifndef ATR_CONSTS_SVH
`define ATR_CONSTS_SVH
`define ATR_OP_RDMUL   8'hC4
`define ATR_OP_RDMULX  8'h29
`define ATR_OP_NMAX    8'hF8
`define ATR_A_DATA     3'h0
`define ATR_A_ERR      3'h1
`define ATR_A_SC       3'h2
`define ATR_A_SN       3'h3
`define ATR_A_CL       3'h4
`define ATR_A_CH       3'h5
`define ATR_A_DH       3'h6
`define ATR_A_ST       3'h7
`define ATR_E_UNC      6
`define ATR_E_ABT      2
`define ATR_S_BSY      7
`define ATR_S_DRQ      3
`define ATR_S_ERR      0
`define ATR_DH_L       6
`define ATR_MAX28      28'hFFF_FFFF
`define ATR_CNT28_ZERO 17'h0_0100
`define ATR_CNT48_ZERO 17'h1_0000
`define ATR_R_CTRL     8'h00
`define ATR_R_LBALO    8'h04
`define ATR_R_LBAHI    8'h08
`define ATR_R_COUNT    8'h0C
`define ATR_R_STATUS   8'h10
`define ATR_R_ISTAT    8'h14
`define ATR_R_IMASK    8'h18
`define ATR_R_RESLO    8'h1C
`define ATR_R_RESHI    8'h20
`define ATR_I_DONE     0
`define ATR_I_ERR      1
`define ATR_WR_STEPS   4'h9
`define ATR_RD_STEPS   4'h8
`endif

//--- include/atr_pkg.sv
// shared types for both ends of the task-file link
package atr_pkg;
	typedef logic [2:0] atr_addr_t;
	typedef enum {ATR_DV_IDLE, ATR_DV_FETCH, ATR_DV_XFER} atr_dev_st_t;
	typedef enum {ATR_HS_IDLE, ATR_HS_WR, ATR_HS_POLL, ATR_HS_PWAIT, ATR_HS_DWAIT,
		ATR_HS_RES, ATR_HS_RWAIT} atr_host_st_t;
endpackage

//--- include/atr_tf_if.sv
// task-file register link between host controller and drive
`timescale 1ns/1ps
interface atr_tf_if;
	import atr_pkg::*;
	logic             wr;
	logic             rd;
	atr_addr_t        addr;
	logic             hob;
	logic [7:0]       wdata;
	logic             rd_ack;
	logic [15:0]      rdata;
	logic             intrq;
	modport dev (input wr, rd, addr, hob, wdata, output rd_ack, rdata, intrq);
	modport hst (output wr, rd, addr, hob, wdata, input rd_ack, rdata, intrq);
endinterface

//--- design/atr_device.sv
// drive end: command decode, sector streaming, native max report
`timescale 1ns/1ps
`include "atr_consts.svh"
module atr_device import atr_pkg::*; #(
	parameter int WORDS = 256
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	atr_tf_if.dev            tf,
	input  wire logic [7:0]  multiple_size,
	input  wire logic [47:0] native_max,
	input  wire logic [15:0] native_max_cyl,
	input  wire logic [3:0]  native_max_head,
	input  wire logic [7:0]  native_max_sect,
	output logic             media_req,
	output logic [47:0]      media_lba,
	input  wire logic        media_ack,
	input  wire logic [15:0] media_word,
	input  wire logic        media_err
);
	localparam int WW = $clog2(WORDS);

	initial begin
		if (WORDS < 2 || (1 << WW) != WORDS)
			$error("WORDS must be a power of two, at least 2");
	end

	atr_dev_st_t     state_reg;
	logic [7:0]      sc_reg, sc_prev_reg, sn_reg, sn_prev_reg;
	logic [7:0]      cl_reg, cl_prev_reg, ch_reg, ch_prev_reg;
	logic [7:0]      dh_reg, err_reg, mult_reg, bcnt_reg;
	logic [16:0]     left_reg;
	logic [WW-1:0]   wcnt_reg;
	logic [15:0]     data_reg;
	logic            ext_reg, irq_evt_reg;
	logic [16:0]     cnt28, cnt48;
	logic [27:0]     lba28, nmax28;
	logic [47:0]     lba48;
	logic [7:0]      status;
	logic            cmd_go, data_rd, stat_rd;
	logic [47:0]     lba48_hold;

	// decoded command parameters from the task file
	assign cnt28  = (sc_reg == 8'h00) ? `ATR_CNT28_ZERO : {9'h000, sc_reg};
	assign cnt48  = ({sc_prev_reg, sc_reg} == 16'h0000) ? `ATR_CNT48_ZERO
		: {1'b0, sc_prev_reg, sc_reg};
	assign lba28  = {dh_reg[3:0], ch_reg, cl_reg, sn_reg};
	assign lba48  = {ch_prev_reg, cl_prev_reg, sn_prev_reg, ch_reg, cl_reg, sn_reg};
	assign nmax28 = (native_max > {20'h0_0000, `ATR_MAX28}) ? `ATR_MAX28
		: native_max[27:0];
	assign cmd_go  = tf.wr && tf.addr == `ATR_A_ST && state_reg == ATR_DV_IDLE;
	assign data_rd = tf.rd && tf.addr == `ATR_A_DATA && state_reg == ATR_DV_XFER;
	assign stat_rd = tf.rd && tf.addr == `ATR_A_ST;
	// busy while media is fetching, ready and seek-complete always set
	always_comb begin
		status = 8'h50;
		status[`ATR_S_BSY] = (state_reg == ATR_DV_FETCH);
		status[`ATR_S_DRQ] = (state_reg == ATR_DV_XFER);
		status[`ATR_S_ERR] = (err_reg != 8'h00);
	end
	assign media_lba = lba48_hold;

	// task file, command sequencer and media walk share one owner
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= ATR_DV_IDLE;
			{sc_reg, sc_prev_reg, sn_reg, sn_prev_reg} <= 32'h0000_0000;
			{cl_reg, cl_prev_reg, ch_reg, ch_prev_reg} <= 32'h0000_0000;
			dh_reg      <= 8'h00;
			err_reg     <= 8'h00;
			mult_reg    <= 8'h00;
			bcnt_reg    <= 8'h00;
			left_reg    <= 17'h0_0000;
			wcnt_reg    <= '0;
			data_reg    <= 16'h0000;
			ext_reg     <= 1'b0;
			irq_evt_reg <= 1'b0;
			media_req   <= 1'b0;
			lba48_hold  <= 48'h0000_0000_0000;
		end else begin
			irq_evt_reg <= 1'b0;
			// writes land only while idle; a busy drive ignores them
			if (tf.wr && state_reg == ATR_DV_IDLE) begin
				case (tf.addr)
				`ATR_A_SC: begin
					sc_prev_reg <= sc_reg;
					sc_reg <= tf.wdata;
				end
				`ATR_A_SN: begin
					sn_prev_reg <= sn_reg;
					sn_reg <= tf.wdata;
				end
				`ATR_A_CL: begin
					cl_prev_reg <= cl_reg;
					cl_reg <= tf.wdata;
				end
				`ATR_A_CH: begin
					ch_prev_reg <= ch_reg;
					ch_reg <= tf.wdata;
				end
				`ATR_A_DH: dh_reg <= tf.wdata;
				default: ;
				endcase
			end
			if (cmd_go) begin
				err_reg  <= 8'h00;
				ext_reg  <= (tf.wdata == `ATR_OP_RDMULX);
				mult_reg <= multiple_size;
				if ((tf.wdata == `ATR_OP_RDMUL || tf.wdata == `ATR_OP_RDMULX)
						&& multiple_size != 8'h00) begin
					left_reg   <= (tf.wdata == `ATR_OP_RDMULX) ? cnt48 : cnt28;
					lba48_hold <= (tf.wdata == `ATR_OP_RDMULX) ? lba48
						: {20'h0_0000, lba28};
					wcnt_reg   <= '0;
					bcnt_reg   <= 8'h00;
					media_req  <= 1'b1;
					state_reg  <= ATR_DV_FETCH;
				end else if (tf.wdata == `ATR_OP_NMAX) begin
					irq_evt_reg <= 1'b1;
					if (dh_reg[`ATR_DH_L]) begin
						sn_reg <= nmax28[7:0];
						cl_reg <= nmax28[15:8];
						ch_reg <= nmax28[23:16];
						dh_reg[3:0] <= nmax28[27:24];
					end else begin
						sn_reg <= native_max_sect;
						cl_reg <= native_max_cyl[7:0];
						ch_reg <= native_max_cyl[15:8];
						dh_reg[3:0] <= native_max_head;
					end
				end else begin
					// unknown opcode or zero block size ends in abort
					err_reg[`ATR_E_ABT] <= 1'b1;
					irq_evt_reg <= 1'b1;
				end
			end
			case (state_reg)
			ATR_DV_FETCH: begin
				if (media_ack) begin
					media_req <= 1'b0;
					if (media_err) begin
						// stop here; report what was left and where
						state_reg <= ATR_DV_IDLE;
						err_reg[`ATR_E_UNC] <= 1'b1;
						irq_evt_reg <= 1'b1;
						sc_reg <= left_reg[7:0];
						sc_prev_reg <= left_reg[15:8];
						sn_reg <= lba48_hold[7:0];
						cl_reg <= lba48_hold[15:8];
						ch_reg <= lba48_hold[23:16];
						if (ext_reg) begin
							sn_prev_reg <= lba48_hold[31:24];
							cl_prev_reg <= lba48_hold[39:32];
							ch_prev_reg <= lba48_hold[47:40];
						end else begin
							dh_reg[3:0] <= lba48_hold[27:24];
						end
					end else begin
						data_reg  <= media_word;
						state_reg <= ATR_DV_XFER;
						// first word of a block wakes the host once
						if (wcnt_reg == '0 && bcnt_reg == 8'h00)
							irq_evt_reg <= 1'b1;
					end
				end
			end
			ATR_DV_XFER: begin
				if (data_rd) begin
					wcnt_reg <= wcnt_reg + 1'b1;
					if (wcnt_reg == WW'(WORDS - 1)) begin
						left_reg   <= left_reg - 17'h0_0001;
						lba48_hold <= lba48_hold + 48'h0000_0000_0001;
						bcnt_reg   <= (bcnt_reg == mult_reg - 8'h01) ? 8'h00
							: bcnt_reg + 8'h01;
						if (left_reg == 17'h0_0001) begin
							state_reg <= ATR_DV_IDLE;
							sc_reg <= 8'h00;
							sc_prev_reg <= 8'h00;
						end else begin
							state_reg <= ATR_DV_FETCH;
							media_req <= 1'b1;
						end
					end else begin
						state_reg <= ATR_DV_FETCH;
						media_req <= 1'b1;
					end
				end
			end
			default: ;
			endcase
		end
	end

	// register reads answer one cycle after the strobe; data holds until the next read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tf.rd_ack <= 1'b0;
			tf.rdata  <= 16'h0000;
		end else begin
			tf.rd_ack <= tf.rd;
			if (tf.rd) begin
				case (tf.addr)
				`ATR_A_DATA: tf.rdata <= data_reg;
				`ATR_A_ERR:  tf.rdata <= {8'h00, err_reg};
				`ATR_A_SC:   tf.rdata <= {8'h00, tf.hob ? sc_prev_reg : sc_reg};
				`ATR_A_SN:   tf.rdata <= {8'h00, tf.hob ? sn_prev_reg : sn_reg};
				`ATR_A_CL:   tf.rdata <= {8'h00, tf.hob ? cl_prev_reg : cl_reg};
				`ATR_A_CH:   tf.rdata <= {8'h00, tf.hob ? ch_prev_reg : ch_reg};
				`ATR_A_DH:   tf.rdata <= {8'h00, dh_reg};
				default:     tf.rdata <= {8'h00, status};
				endcase
			end
		end
	end

	// status read drops the line, but a new event in that cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tf.intrq <= 1'b0;
		else
			tf.intrq <= irq_evt_reg | (tf.intrq & ~stat_rd);
	end
endmodule

//--- design/atr_host.sv
// host end: AXI4-Lite register front, task-file command engine
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "atr_consts.svh"
module atr_host import atr_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	output logic             word_valid,
	output logic [15:0]      word_data,
	atr_tf_if.hst            tf
);
	atr_host_st_t    state_reg;
	logic [7:0]      aw_addr_reg;
	logic [31:0]     w_data_reg, ctrl_reg, lba_lo_reg;
	logic [3:0]      w_strb_reg, step_reg;
	logic            aw_have_reg, w_have_reg, busy_reg;
	logic [15:0]     lba_hi_reg, count_reg;
	logic [1:0]      istat_reg, imask_reg;
	logic [7:0]      stat_reg, err_byte_reg, sc_byte_reg;
	logic [7:0]      res_reg [0:`ATR_RD_STEPS];
	logic            do_wr, go, done_evt, ext;
	logic [31:0]     wmerged;

	// apply byte strobes onto the old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	assign do_wr   = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wmerged = merge(32'h0000_0000, w_data_reg, w_strb_reg);
	assign go      = do_wr && aw_addr_reg == `ATR_R_CTRL && wmerged[0] && !busy_reg;
	assign ext     = (ctrl_reg[15:8] == `ATR_OP_RDMULX);

	// write channels are taken in either order, answered after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg > `ATR_R_IMASK || aw_addr_reg[1:0] != 2'b00)
					? 2'b11 : 2'b00; // above the mask register or misaligned: decode error
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;

	// software registers; start bit is a pulse, not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg   <= 32'h0000_0000;
			lba_lo_reg <= 32'h0000_0000;
			lba_hi_reg <= 16'h0000;
			count_reg  <= 16'h0000;
			imask_reg  <= 2'b00;
			istat_reg  <= 2'b00;
			irq        <= 1'b0;
		end else begin
			if (do_wr) begin
				case (aw_addr_reg)
				`ATR_R_CTRL:  if (!busy_reg)
					ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_FF02;
				`ATR_R_LBALO: lba_lo_reg <= merge(lba_lo_reg, w_data_reg, w_strb_reg);
				`ATR_R_LBAHI: lba_hi_reg <= wmerged[15:0];
				`ATR_R_COUNT: count_reg <= wmerged[15:0];
				`ATR_R_IMASK: imask_reg <= wmerged[1:0];
				default: ;
				endcase
			end
			// a new event in the clearing cycle survives the clear
			istat_reg <= (istat_reg & ~((do_wr && aw_addr_reg == `ATR_R_ISTAT)
				? wmerged[1:0] : 2'b00))
				| {done_evt && stat_reg[`ATR_S_ERR], done_evt};
			irq <= |(istat_reg & imask_reg);
		end
	end

	// read channel: one outstanding read, answered the next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr)
			`ATR_R_CTRL:   s_axi_rdata <= ctrl_reg;
			`ATR_R_LBALO:  s_axi_rdata <= lba_lo_reg;
			`ATR_R_LBAHI:  s_axi_rdata <= {16'h0000, lba_hi_reg};
			`ATR_R_COUNT:  s_axi_rdata <= {16'h0000, count_reg};
			`ATR_R_STATUS: s_axi_rdata <= {sc_byte_reg, err_byte_reg, stat_reg,
				7'h00, busy_reg};
			`ATR_R_ISTAT:  s_axi_rdata <= {30'h0000_0000, istat_reg};
			`ATR_R_IMASK:  s_axi_rdata <= {30'h0000_0000, imask_reg};
			`ATR_R_RESLO:  s_axi_rdata <= {ext ? res_reg[6] : {4'h0, res_reg[5][3:0]},
				res_reg[4], res_reg[3], res_reg[2]};
			`ATR_R_RESHI:  s_axi_rdata <= {16'h0000, res_reg[8], res_reg[7]};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b11;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	// task-file engine: load registers, poll, drain words, fetch results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg  <= ATR_HS_IDLE;
			step_reg   <= 4'h0;
			busy_reg   <= 1'b0;
			done_evt   <= 1'b0;
			stat_reg   <= 8'h00;
			err_byte_reg <= 8'h00;
			sc_byte_reg  <= 8'h00;
			word_valid <= 1'b0;
			word_data  <= 16'h0000;
			tf.wr <= 1'b0;
			tf.rd <= 1'b0;
			tf.addr <= `ATR_A_DATA;
			tf.hob <= 1'b0;
			tf.wdata <= 8'h00;
			for (int i = 0; i <= `ATR_RD_STEPS; i++)
				res_reg[i] <= 8'h00;
		end else begin
			done_evt   <= 1'b0;
			word_valid <= 1'b0;
			tf.wr <= 1'b0;
			tf.rd <= 1'b0;
			case (state_reg)
			ATR_HS_IDLE: if (go) begin
				busy_reg <= 1'b1;
				step_reg <= 4'h0;
				state_reg <= ATR_HS_WR;
			end
			ATR_HS_WR: begin
				// each byte pair: previous (high) first, then current (low)
				tf.wr <= 1'b1;
				step_reg <= step_reg + 4'h1;
				case (step_reg)
				4'h0: {tf.addr, tf.wdata} <= {`ATR_A_SC, count_reg[15:8]};
				4'h1: {tf.addr, tf.wdata} <= {`ATR_A_SC, count_reg[7:0]};
				4'h2: {tf.addr, tf.wdata} <= {`ATR_A_SN, lba_lo_reg[31:24]};
				4'h3: {tf.addr, tf.wdata} <= {`ATR_A_SN, lba_lo_reg[7:0]};
				4'h4: {tf.addr, tf.wdata} <= {`ATR_A_CL, lba_hi_reg[7:0]};
				4'h5: {tf.addr, tf.wdata} <= {`ATR_A_CL, lba_lo_reg[15:8]};
				4'h6: {tf.addr, tf.wdata} <= {`ATR_A_CH, lba_hi_reg[15:8]};
				4'h7: {tf.addr, tf.wdata} <= {`ATR_A_CH, lba_lo_reg[23:16]};
				4'h8: {tf.addr, tf.wdata} <= {`ATR_A_DH, 1'b1, ctrl_reg[1], 2'b10,
					lba_lo_reg[27:24]};
				default: {tf.addr, tf.wdata} <= {`ATR_A_ST, ctrl_reg[15:8]};
				endcase
				if (step_reg == `ATR_WR_STEPS)
					state_reg <= ATR_HS_POLL;
			end
			ATR_HS_POLL: begin
				tf.rd <= 1'b1;
				tf.addr <= `ATR_A_ST;
				tf.hob <= 1'b0;
				state_reg <= ATR_HS_PWAIT;
			end
			ATR_HS_PWAIT: if (tf.rd_ack) begin
				if (tf.rdata[`ATR_S_BSY]) begin
					state_reg <= ATR_HS_POLL;
				end else if (tf.rdata[`ATR_S_DRQ]) begin
					tf.rd <= 1'b1;
					tf.addr <= `ATR_A_DATA;
					state_reg <= ATR_HS_DWAIT;
				end else begin
					stat_reg <= tf.rdata[7:0];
					step_reg <= 4'h0;
					state_reg <= ATR_HS_RES;
				end
			end
			ATR_HS_DWAIT: if (tf.rd_ack) begin
				word_valid <= 1'b1;
				word_data <= tf.rdata;
				state_reg <= ATR_HS_POLL;
			end
			ATR_HS_RES: begin
				// error, count, then address bytes low half and high half
				tf.rd <= 1'b1;
				tf.hob <= (step_reg > 4'h5);
				case (step_reg)
				4'h0: tf.addr <= `ATR_A_ERR;
				4'h1: tf.addr <= `ATR_A_SC;
				4'h2, 4'h6: tf.addr <= `ATR_A_SN;
				4'h3, 4'h7: tf.addr <= `ATR_A_CL;
				4'h5: tf.addr <= `ATR_A_DH;
				default: tf.addr <= `ATR_A_CH;
				endcase
				state_reg <= ATR_HS_RWAIT;
			end
			ATR_HS_RWAIT: if (tf.rd_ack) begin
				res_reg[step_reg] <= tf.rdata[7:0];
				if (step_reg == 4'h0)
					err_byte_reg <= tf.rdata[7:0];
				if (step_reg == 4'h1)
					sc_byte_reg <= tf.rdata[7:0];
				step_reg <= step_reg + 4'h1;
				if (step_reg == `ATR_RD_STEPS) begin
					busy_reg <= 1'b0;
					done_evt <= 1'b1;
					state_reg <= ATR_HS_IDLE;
				end else begin
					state_reg <= ATR_HS_RES;
				end
			end
			default: state_reg <= ATR_HS_IDLE;
			endcase
		end
	end
endmodule

//--- testbench/atr_link_assertions.sv
// task-file link checker: read answers and contents of returned registers
`timescale 1ns/1ps
`include "atr_consts.svh"
module atr_link_assertions import atr_pkg::*; (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        wr,
	input wire logic        rd,
	input wire atr_addr_t   addr,
	input wire logic        rd_ack,
	input wire logic [15:0] rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// one answer per read, one cycle later, never unasked
	chk_ack_after_rd: assert property (rd |=> rd_ack)
		else $error("read not answered next cycle");
	chk_ack_has_cause: assert property (rd_ack |-> $past(rd))
		else $error("answer without read");
	// read data stands between answers
	chk_rdata_holds: assert property (!rd_ack |-> $stable(rdata))
		else $error("read data moved without answer");
	// byte registers keep the upper byte clear
	chk_byte_regs: assert property (
		rd_ack && $past(addr) != `ATR_A_DATA |-> rdata[15:8] == 8'h00)
		else $error("upper byte set on byte register");
	// status: ready and seek set, fault and unused bits clear
	chk_status_fixed: assert property (
		rd_ack && $past(addr) == `ATR_A_ST |-> rdata[6] && rdata[4] && !rdata[5]
		&& rdata[2:1] == 2'h0)
		else $error("status fixed bits wrong");
	chk_bsy_drq_excl: assert property (
		rd_ack && $past(addr) == `ATR_A_ST |-> !(rdata[7] && rdata[3]))
		else $error("busy together with data request");
	// only media and abort errors are ever reported
	chk_error_bits: assert property (
		rd_ack && $past(addr) == `ATR_A_ERR |-> (rdata[7:0] & 8'hBB) == 8'h00)
		else $error("unexpected error bit");
	chk_strobe_excl: assert property (!(wr && rd))
		else $error("write and read strobes together");
endmodule

//--- testbench/ata_read_multiple_native_max_tb.sv
// self-checking bench: host and drive ends joined over the task-file link
`timescale 1ns/1ps
`include "atr_consts.svh"
module ata_read_multiple_native_max_tb;
	import atr_pkg::*;
	localparam int WORDS = 2;
	logic        aclk = '0;
	logic        aresetn = '0;
	logic [7:0]  awaddr = '0, araddr = '0, msz = '0, nm_sect = '0;
	logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic [31:0] wdata = '0, rdata, status;
	logic        awready, wready, bvalid, arready, rvalid, irq, word_valid, media_req;
	logic [1:0]  bresp, rresp;
	logic [15:0] word_data, nm_cyl = '0, mword = '0;
	logic [47:0] nmax = '0, media_lba, lba0 = '0;
	logic [3:0]  nm_head = '0;
	logic        mack = '0, merr = '0, iq_d = '0;
	logic [15:0] exp_q[$];
	int          fail_count = 0, cmp_count = 0, dly = 0, wcnt = 0, err_w = -1, rises = 0;

	always #2 aclk = ~aclk;

	atr_tf_if tf ();
	atr_host atr_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.word_valid(word_valid), .word_data(word_data), .tf(tf.hst));
	atr_device #(.WORDS(WORDS)) atr_device_inst (.aclk(aclk), .aresetn(aresetn), .tf(tf.dev),
		.multiple_size(msz), .native_max(nmax), .native_max_cyl(nm_cyl),
		.native_max_head(nm_head), .native_max_sect(nm_sect), .media_req(media_req),
		.media_lba(media_lba), .media_ack(mack), .media_word(mword), .media_err(merr));
	atr_link_assertions atr_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
		.wr(tf.wr), .rd(tf.rd), .addr(tf.addr), .rd_ack(tf.rd_ack), .rdata(tf.rdata));

	task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		chk_val(48'(got), 48'(exp), "data word");
	endtask

	// ready is looked at mid-cycle, so it is what the next rising edge samples
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_go, w_go, b_go;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		b_go = 1'h0;
		while (!b_go) begin
			@(negedge aclk);
			aw_go = awvalid && awready;
			w_go  = wvalid && wready;
			b_go  = bvalid;
			r     = bresp;
			@(posedge aclk);
			if (aw_go) awvalid <= 1'h0;
			if (w_go) wvalid <= 1'h0;
		end
		bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_go, r_go;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		r_go = 1'h0;
		while (!r_go) begin
			@(negedge aclk);
			ar_go = arvalid && arready;
			r_go  = rvalid;
			d     = rdata;
			r     = rresp;
			@(posedge aclk);
			if (ar_go) arvalid <= 1'h0;
		end
		rready <= 1'h0;
	endtask

	// issue one command and poll until the controller is idle again
	task automatic cmd(input logic [7:0] op, input logic lm, input logic [47:0] lba,
		input logic [15:0] cnt);
		logic [1:0] r;
		lba0  = lba;
		wcnt  = 0;
		rises = 0;
		axi_wr(`ATR_R_LBALO, lba[31:0], r);
		axi_wr(`ATR_R_LBAHI, {16'h0000, lba[47:32]}, r);
		axi_wr(`ATR_R_COUNT, {16'h0000, cnt}, r);
		axi_wr(`ATR_R_CTRL, {16'h0000, op, 6'h00, lm, 1'h1}, r);
		repeat (4) @(posedge aclk);
		status = 32'h0000_0001;
		for (int i = 0; i < 9000 && status[0]; i++) axi_rd(`ATR_R_STATUS, status, r);
		chk_val(48'(status[0]), 48'h0, "still busy");
		chk_val(48'(exp_q.size()), 48'h0, "words left");
	endtask

	// media side: 0..3 cycle answer, one word per request, error where planned
	always @(posedge aclk) begin
		logic [15:0] w;
		mack <= 1'h0;
		merr <= 1'h0;
		if (media_req && !mack) begin
			if (dly != 0) begin
				dly <= dly - 1;
			end else begin
				w = 16'($urandom);
				if (wcnt % WORDS == 0) chk_val(media_lba, lba0 + 48'(wcnt / WORDS), "lba");
				if (wcnt == err_w) merr <= 1'h1;
				else exp_q.push_back(w);
				mack  <= 1'h1;
				mword <= w;
				dly   <= $urandom_range(3);
				wcnt++;
			end
		end
	end

	// host words must match media words in order; count interrupt rises
	always @(posedge aclk) begin
		iq_d <= tf.intrq;
		if (tf.intrq && !iq_d) rises++;
		if (word_valid) chk_word(word_data, exp_q.size() ? exp_q.pop_front() : ~word_data);
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// hang guard, far above the thousand or so cycles the sequence needs
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		$display("mismatch at %0t: timeout", $time);
		final_report();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [47:0] v;
		d = $urandom(47761);
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		// reset value and refused addresses
		axi_rd(`ATR_R_IMASK, d, r);
		chk_val(d, 48'h0, "mask reset");
		axi_rd(8'h40, d, r);
		chk_val({d, r}, 48'h3, "unmapped read");
		axi_wr(8'h40, 32'h0000_0000, r);
		chk_val(r, 48'h3, "unmapped write");
		// native max: clamped LBA, plain LBA, CHS form
		for (int k = 0; k < 3; k++) begin
			nmax    <= k ? 48'($urandom) & 48'h0000_0FFF_FFFF : {16'h0001, 32'($urandom)};
			nm_cyl  <= 16'($urandom);
			nm_head <= 4'($urandom);
			nm_sect <= 8'($urandom);
			cmd(`ATR_OP_NMAX, k < 2, 48'h0, 16'h0000);
			v = (k == 2) ? {20'h0, nm_head, nm_cyl, nm_sect} : (k ? nmax : 48'h0FFF_FFFF);
			axi_rd(`ATR_R_RESLO, d, r);
			chk_val(d, v, "native max");
			chk_val(status[15:8], 48'h50, "native status");
		end
		// clean reads, block size 1..3, one interrupt per block
		for (int k = 1; k < 4; k++) begin
			msz <= 8'(k);
			v = 48'($urandom_range(5, 1));
			cmd(`ATR_OP_RDMUL, 1'h1, 48'($urandom) & 48'h0000_0FFF_FFFF, v[15:0]);
			chk_val(48'(rises), (v + k - 1) / k, "block interrupts");
			chk_val(48'(wcnt), v * WORDS, "words read");
			chk_val(status, 48'h5000, "clean status");
		end
		// count zero with a media error: 48-bit at sector 2, 28-bit at sector 1
		for (int k = 0; k < 2; k++) begin
			msz   <= 8'h02;
			err_w = (2 - k) * WORDS;
			v = {k ? 16'h0 : 16'($urandom), k ? 4'h0 : 4'($urandom), 28'($urandom)};
			cmd(k ? `ATR_OP_RDMUL : `ATR_OP_RDMULX, 1'h1, v, 16'h0000);
			v = v + 48'(2 - k);
			chk_val(status, k ? 48'hFF40_5100 : 48'hFE40_5100, "error status");
			chk_val(48'(wcnt), 48'(err_w + 1), "read past error");
			axi_rd(`ATR_R_RESLO, d, r);
			chk_val(d, k ? {4'h0, v[27:0]} : v[31:0], "failing address");
			axi_rd(`ATR_R_RESHI, d, r);
			if (!k) chk_val(d, v[47:32], "failing address high");
		end
		err_w = -1;
		// aborts: zero block size, then an unsupported opcode
		for (int k = 0; k < 2; k++) begin
			msz <= 8'(2 * k);
			cmd(k ? 8'h20 : `ATR_OP_RDMUL, 1'h1, 48'h1, 16'h0001);
			chk_val(status[23:0], 48'h04_5100, "abort status");
			chk_val(48'(wcnt), 48'h0, "media touched");
		end
		// interrupt line: masked, unmasked, cleared by writing ones
		chk_val(irq, 48'h0, "masked irq");
		axi_rd(`ATR_R_ISTAT, d, r);
		chk_val(d, 48'h3, "event bits");
		axi_wr(`ATR_R_IMASK, 32'h0000_0002, r);
		repeat (2) @(posedge aclk);
		chk_val(irq, 48'h1, "unmasked irq");
		axi_wr(`ATR_R_ISTAT, 32'h0000_0003, r);
		repeat (2) @(posedge aclk);
		chk_val(irq, 48'h0, "cleared irq");
		final_report();
	end
endmodule
